// ### src/pcs_pkg.sv
// How it works
// - 50% duty for integer ratios 1,2,3..; fractional ratios give alternating unequal half periods
// - after reset the system clock runs from the 16 MHz internal oscillator
// - differing power levels of current and target mode start a stepped ramp
// - re-entering the same mode ramps too once its power level was changed
// - ramp-down uses initial increment, change rate and end divider of current source
// - ramp-up uses initial increment, change rate and start divider of target source
// - on first revision only the io core may change the system divider
// - one step lasts the duration count of 16 MHz oscillator cycles
// - divider change holds initial increment and rate that grows steps on ramp-down and shrinks them on ramp-up
package pcs_pkg;
  localparam int DIV_W = 20;
  localparam logic [DIV_W-1:0] DIV_SCALE = 20'h003e8;
  localparam logic [1:0] IRC_SOURCE = 2'h0;
  localparam logic [1:0] DEFAULT_RUN_MODE = 2'h0;
  localparam logic [1:0] IO_CORE_ID = 2'h2;
  localparam int MODE_COUNT = 3;
  localparam int SOURCE_COUNT = 4;
  // byte offsets
  localparam logic [7:0] MODE_CTL_OFS = 8'h00;
  localparam logic [7:0] MODE_CFG_OFS = 8'h04;
  localparam logic [7:0] SYS_DIV_OFS = 8'h10;
  localparam logic [7:0] SDUR_OFS = 8'h14;
  localparam logic [7:0] DIVC_OFS = 8'h20;
  localparam logic [7:0] DIVE_OFS = 8'h30;
  localparam logic [7:0] DIVS_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h50;
  // field positions
  localparam int PWR_LSB = 0;
  localparam int SRC_LSB = 4;
  localparam int BUSY_BIT = 8;
  localparam int RATE_LSB = 16;
  // reset values
  localparam logic [7:0] SYS_DIV_RST = 8'h01;
  localparam logic [15:0] SDUR_RST = 16'h0010;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {IDLE, DOWN, SWITCH, UP} ramp_state_type;
  typedef struct packed {
    logic [1:0] src;
    logic [2:0] pwr;
  } mode_cfg_type;
  typedef struct packed {
    logic [15:0] rate;
    logic [15:0] init;
    logic [DIV_W-1:0] dive;
    logic [DIV_W-1:0] divs;
  } pcs_set_type;
endpackage : pcs_pkg

// ### src/frac_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
// half period of div/1000 cycles on average: integer and fractional ratios, even duty for integer ratios
module frac_clock_divider #(
  parameter int DIV_W = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // ratio in thousandths, at least 1000
  input wire logic [DIV_W-1:0] ratio,
  // divided clock
  output logic clk_out
);
  logic [DIV_W-1:0] acc_reg;
  logic clk_reg;
  wire logic [DIV_W-1:0] acc_sum = acc_reg + pcs_pkg::DIV_SCALE;
  wire logic wrap = acc_sum >= ratio;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_reg <= '0;
      clk_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= wrap ? acc_sum - ratio : acc_sum;
      clk_reg <= clk_reg ^ wrap;
    end
  end
  assign clk_out = clk_reg;
  a_unit_ratio_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    ratio == pcs_pkg::DIV_SCALE && $past(ratio) == pcs_pkg::DIV_SCALE && $past(aresetn)
    |=> clk_reg != $past(clk_reg)) else $error("unit ratio clock did not toggle");
endmodule : frac_clock_divider
`default_nettype wire

// ### src/pcs_clock_unit.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_unit #(
  parameter bit FIRST_REVISION = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // id of the core behind the current write
  input wire logic [1:0] write_core_id,
  // 16 MHz oscillator pin
  input wire logic internal_rc_oscillator,
  // clock control outputs
  output logic [1:0] sys_clk_source_sel,
  output logic sys_clk_out,
  output logic ramp_active
);
  localparam int DIV_W_L = pcs_pkg::DIV_W;
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg, wcore_reg;
  logic [1:0] cur_mode_reg, tgt_mode_reg, cur_src_reg;
  logic [2:0] cur_pwr_reg;
  logic [7:0] sys_div_reg;
  logic [15:0] sdur_reg, step_cnt_reg, inc_reg;
  logic [DIV_W_L-1:0] div_reg;
  logic start_reg;
  logic [2:0] irc_sync_reg;
  pcs_pkg::mode_cfg_type mode_cfg_reg [pcs_pkg::MODE_COUNT];
  pcs_pkg::pcs_set_type pcs_reg [pcs_pkg::SOURCE_COUNT];
  pcs_pkg::ramp_state_type state_reg;

  // bus handshake
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire logic do_read = arvalid && arready;

  // write decode
  wire logic [1:0] wsel = awaddr_reg[3:2];
  wire logic wr_ctl = awaddr_reg == pcs_pkg::MODE_CTL_OFS;
  wire logic wr_cfg = awaddr_reg[7:4] == 4'h0 && wsel != 2'h0;
  wire logic wr_sdiv = awaddr_reg == pcs_pkg::SYS_DIV_OFS;
  wire logic wr_sdur = awaddr_reg == pcs_pkg::SDUR_OFS;
  wire logic wr_divc = awaddr_reg[7:4] == pcs_pkg::DIVC_OFS[7:4];
  wire logic wr_dive = awaddr_reg[7:4] == pcs_pkg::DIVE_OFS[7:4];
  wire logic wr_divs = awaddr_reg[7:4] == pcs_pkg::DIVS_OFS[7:4];
  wire logic wr_known = wr_ctl | wr_cfg | wr_sdiv | wr_sdur | wr_divc | wr_dive | wr_divs
                        | awaddr_reg == pcs_pkg::STATUS_OFS;
  wire logic [1:0] cfg_idx = wsel - 2'h1;
  // first revision: only the io core reaches the system divider
  wire logic sdiv_allowed = !FIRST_REVISION || wcore_reg == pcs_pkg::IO_CORE_ID;
  wire logic [31:0] cur_word = wr_ctl ? {30'h0, tgt_mode_reg}
    : wr_cfg ? {24'h0, 2'h0, mode_cfg_reg[cfg_idx].src, 1'b0, mode_cfg_reg[cfg_idx].pwr}
    : wr_sdiv ? {24'h0, sys_div_reg} : wr_sdur ? {16'h0, sdur_reg}
    : wr_divc ? {pcs_reg[wsel].rate, pcs_reg[wsel].init}
    : wr_dive ? {12'h0, pcs_reg[wsel].dive} : {12'h0, pcs_reg[wsel].divs};
  wire logic [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
                                 {8{wstrb_reg[0]}}};
  wire logic [31:0] new_word = (cur_word & ~strb_mask) | (wdata_reg & strb_mask);
  wire logic [1:0] new_mode = new_word[1:0];
  wire logic mode_ok = new_mode < 2'(pcs_pkg::MODE_COUNT);

  // read decode
  wire logic [1:0] rsel = araddr[3:2];
  wire logic [1:0] rcfg = rsel - 2'h1;
  wire logic rd_cfg = araddr[7:4] == 4'h0 && rsel != 2'h0;
  wire logic [31:0] status_word = {2'h0, cur_pwr_reg, 1'b0, cur_src_reg, div_reg,
                                   2'(state_reg), cur_mode_reg};
  wire logic rd_known = araddr[1:0] == 2'h0 && (araddr[7:4] <= 4'h4 || araddr == pcs_pkg::STATUS_OFS)
    && araddr[7:4] != 4'h1 || araddr == pcs_pkg::SYS_DIV_OFS || araddr == pcs_pkg::SDUR_OFS;
  wire logic [31:0] rd_word = araddr == pcs_pkg::MODE_CTL_OFS
      ? {23'h0, state_reg != pcs_pkg::IDLE, 6'h0, cur_mode_reg}
    : rd_cfg ? {26'h0, mode_cfg_reg[rcfg].src, 1'b0, mode_cfg_reg[rcfg].pwr}
    : araddr == pcs_pkg::SYS_DIV_OFS ? {24'h0, sys_div_reg}
    : araddr == pcs_pkg::SDUR_OFS ? {16'h0, sdur_reg}
    : araddr[7:4] == 4'h2 ? {pcs_reg[rsel].rate, pcs_reg[rsel].init}
    : araddr[7:4] == 4'h3 ? {12'h0, pcs_reg[rsel].dive}
    : araddr[7:4] == 4'h4 ? {12'h0, pcs_reg[rsel].divs}
    : araddr == pcs_pkg::STATUS_OFS ? status_word : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      wcore_reg <= 2'h0;
      bresp_reg <= pcs_pkg::RESP_OKAY;
      rresp_reg <= pcs_pkg::RESP_OKAY;
      rdata_reg <= 32'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
        wcore_reg <= write_core_id;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && bready)
        bvalid_reg <= 1'b0;
      if (do_read)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_known ? rd_word : 32'h0;
        rresp_reg <= rd_known ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      end
      else if (rvalid_reg && rready)
        rvalid_reg <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_div_reg <= pcs_pkg::SYS_DIV_RST;
      sdur_reg <= pcs_pkg::SDUR_RST;
      tgt_mode_reg <= pcs_pkg::DEFAULT_RUN_MODE;
      start_reg <= 1'b0;
      for (int i = 0; i < pcs_pkg::MODE_COUNT; i++) mode_cfg_reg[i] <= '0;
      for (int i = 0; i < pcs_pkg::SOURCE_COUNT; i++) pcs_reg[i] <= '0;
    end
    else
    begin
      // a request while ramping is dropped; busy shows it
      start_reg <= do_write && wr_ctl && mode_ok && state_reg == pcs_pkg::IDLE;
      if (do_write && wr_ctl && mode_ok && state_reg == pcs_pkg::IDLE)
        tgt_mode_reg <= new_mode;
      if (do_write && wr_cfg)
        mode_cfg_reg[cfg_idx] <= {new_word[5:4], new_word[2:0]};
      if (do_write && wr_sdiv && sdiv_allowed && new_word[7:0] != 8'h00)
        sys_div_reg <= new_word[7:0];
      if (do_write && wr_sdur)
        sdur_reg <= new_word[15:0];
      if (do_write && wr_divc)
        {pcs_reg[wsel].rate, pcs_reg[wsel].init} <= new_word;
      if (do_write && wr_dive)
        pcs_reg[wsel].dive <= new_word[DIV_W_L-1:0];
      if (do_write && wr_divs)
        pcs_reg[wsel].divs <= new_word[DIV_W_L-1:0];
    end
  end

  // oscillator ticks: bits 0,1 synchronise, bit 2 only for the edge
  wire logic irc_edge = irc_sync_reg[1] && !irc_sync_reg[2];
  wire logic [15:0] sdur_eff = sdur_reg == 16'h0 ? 16'h1 : sdur_reg;
  wire logic step_pulse = irc_edge && step_cnt_reg == sdur_eff - 16'h1;
  wire logic ramping = state_reg == pcs_pkg::DOWN || state_reg == pcs_pkg::UP;

  // ramp datapath
  pcs_pkg::mode_cfg_type tgt_cfg;
  assign tgt_cfg = mode_cfg_reg[tgt_mode_reg];
  wire logic pwr_equal = tgt_cfg.pwr == cur_pwr_reg;
  pcs_pkg::pcs_set_type down_set, up_set;
  assign down_set = pcs_reg[cur_src_reg];
  assign up_set = pcs_reg[tgt_cfg.src];
  wire logic [DIV_W_L-1:0] final_div = DIV_W_L'(sys_div_reg) * pcs_pkg::DIV_SCALE;
  wire logic [DIV_W_L-1:0] inc_eff = inc_reg == 16'h0 ? DIV_W_L'(1) : DIV_W_L'(inc_reg);
  wire logic [DIV_W_L:0] down_sum = {1'b0, div_reg} + {1'b0, inc_eff};
  wire logic down_done = down_sum >= {1'b0, down_set.dive};
  wire logic up_done = div_reg <= final_div + inc_eff;
  wire logic [15:0] inc_grow = inc_reg + down_set.rate;
  wire logic [15:0] inc_shrink = inc_reg > up_set.rate ? inc_reg - up_set.rate : 16'h1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irc_sync_reg <= 3'h0;
      step_cnt_reg <= 16'h0;
      state_reg <= pcs_pkg::IDLE;
      cur_src_reg <= pcs_pkg::IRC_SOURCE;
      cur_mode_reg <= pcs_pkg::DEFAULT_RUN_MODE;
      cur_pwr_reg <= 3'h0;
      div_reg <= pcs_pkg::DIV_SCALE;
      inc_reg <= 16'h0;
    end
    else
    begin
      irc_sync_reg <= {irc_sync_reg[1:0], internal_rc_oscillator};
      if (!ramping)
        step_cnt_reg <= 16'h0;
      else if (irc_edge)
        step_cnt_reg <= step_pulse ? 16'h0 : step_cnt_reg + 16'h1;
      case (state_reg)
        pcs_pkg::IDLE:
          if (start_reg)
          begin
            cur_mode_reg <= tgt_mode_reg;
            cur_pwr_reg <= tgt_cfg.pwr;
            if (pwr_equal)
            begin
              cur_src_reg <= tgt_cfg.src;
              div_reg <= final_div;
            end
            else
            begin
              inc_reg <= down_set.init;
              state_reg <= pcs_pkg::DOWN;
            end
          end
        pcs_pkg::DOWN:
          if (step_pulse)
          begin
            div_reg <= down_done ? down_set.dive : down_sum[DIV_W_L-1:0];
            inc_reg <= inc_grow;
            if (down_done) state_reg <= pcs_pkg::SWITCH;
          end
        pcs_pkg::SWITCH:
        begin
          cur_src_reg <= tgt_cfg.src;
          div_reg <= up_set.divs;
          inc_reg <= up_set.init;
          state_reg <= pcs_pkg::UP;
        end
        pcs_pkg::UP:
          if (step_pulse)
          begin
            div_reg <= up_done ? final_div : div_reg - inc_eff;
            inc_reg <= inc_shrink;
            if (up_done) state_reg <= pcs_pkg::IDLE;
          end
        default: state_reg <= pcs_pkg::IDLE;
      endcase
    end
  end

  assign sys_clk_source_sel = cur_src_reg;
  assign ramp_active = state_reg != pcs_pkg::IDLE;

  frac_clock_divider #(.DIV_W(DIV_W_L)) u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio(div_reg < pcs_pkg::DIV_SCALE ? pcs_pkg::DIV_SCALE : div_reg),
    .clk_out(sys_clk_out)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start_unequal;
    state_reg == pcs_pkg::IDLE && start_reg && !pwr_equal;
  endsequence
  sequence s_same_mode_unequal;
    s_start_unequal ##0 tgt_mode_reg == cur_mode_reg;
  endsequence
  a_reset_source: assert property (disable iff (1'b0)
    !aresetn |=> cur_src_reg == pcs_pkg::IRC_SOURCE && div_reg == pcs_pkg::DIV_SCALE)
    else $error("reset did not select the internal oscillator");
  a_unequal_ramps: assert property (s_start_unequal |=> state_reg == pcs_pkg::DOWN
    && inc_reg == $past(down_set.init)) else $error("power change did not start a ramp");
  a_same_mode_ramp: assert property (s_same_mode_unequal |=> ramp_active)
    else $error("same mode re-entry did not ramp");
  a_equal_direct: assert property (state_reg == pcs_pkg::IDLE && start_reg && pwr_equal
    |=> state_reg == pcs_pkg::IDLE && div_reg == $past(final_div)
    && cur_src_reg == $past(tgt_cfg.src)) else $error("equal power did not apply at once");
  a_div_outside_ramp: assert property (state_reg == pcs_pkg::IDLE && !start_reg
    |=> $stable(div_reg) && $stable(cur_src_reg)) else $error("divider moved without a transition");
  a_down_end: assert property (state_reg == pcs_pkg::DOWN && step_pulse && down_done
    |=> state_reg == pcs_pkg::SWITCH ##1 div_reg == $past(up_set.divs)
    && state_reg == pcs_pkg::UP) else $error("ramp-down end handling wrong");
  a_up_descends: assert property (state_reg == pcs_pkg::UP && step_pulse && !up_done
    |=> div_reg == $past(div_reg) - $past(inc_eff)) else $error("ramp-up step wrong");
  a_step_pacing: assert property (ramping && irc_edge
    |=> step_cnt_reg == ($past(step_pulse) ? 16'h0 : $past(step_cnt_reg) + 16'h1))
    else $error("step not paced by oscillator count");
  a_step_hold: assert property (ramping && !irc_edge |=> $stable(step_cnt_reg))
    else $error("step counter moved without an oscillator edge");
  a_rate_growth: assert property (state_reg == pcs_pkg::DOWN && step_pulse
    |=> inc_reg == $past(inc_reg) + $past(down_set.rate)) else $error("increment did not grow");
  a_sysdiv_guard: assert property (do_write && wr_sdiv && !sdiv_allowed
    |=> $stable(sys_div_reg)) else $error("foreign core changed the system divider");
endmodule : pcs_clock_unit
`default_nettype wire

// ### src/dummy_unused_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb/rc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// free-running 16 mhz source, phase unrelated to aclk
module rc_osc_model (
  // oscillator pin
  output logic osc
);
  initial
  begin
    osc = 1'b0;
    #3.7;
    forever #31.25 osc = ~osc;
  end
endmodule : rc_osc_model
`default_nettype wire

// ### tb/progressive_clock_switching_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module progressive_clock_switching_tb_top;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } rexp_type;
  localparam logic [31:0] SM = 32'h3bffffff;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, osc, clk_out, ramp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, s;
  logic [1:0] bresp, rresp, write_core_id, src_sel;
  logic [3:0] wstrb;
  logic [2:0] prot;
  logic [19:0] dv;
  int errors, n_tests, n;
  time t0;
  rexp_type e;
  rexp_type er[$];
  logic [1:0] eb[$];

  rc_osc_model i_rc_osc_model (.osc(osc));
  pcs_clock_unit #(.FIRST_REVISION(1'b1)) i_pcs_clock_unit (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .write_core_id(write_core_id), .internal_rc_oscillator(osc),
    .sys_clk_source_sel(src_sel), .sys_clk_out(clk_out), .ramp_active(ramp)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  function automatic logic [31:0] st(input logic [1:0] md, input logic [19:0] v,
    input logic [1:0] sr, input logic [2:0] pw);
    st = {2'h0, pw, 1'b0, sr, v, 2'h0, md};
  endfunction : st

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r = 2'h0, input logic [1:0] id = 2'h0);
    @(posedge aclk);
    eb.push_back(r);
    awaddr <= a;
    wdata <= v;
    write_core_id <= id;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
    input logic [31:0] m = 32'hffffffff, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    er.push_back(rexp_type'{v, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
  endtask : rd

  // bounded wait for the ramp to finish
  task automatic wait_idle();
    n = 0;
    while (ramp && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, ramp}, 32'h0);
  endtask : wait_idle

  // results are judged in arrival order
  always @(posedge aclk)
  begin
    if (aresetn && bvalid && bready)
      chk({30'h0, bresp}, {30'h0, eb.pop_front()});
    if (aresetn && rvalid && rready)
    begin
      e = er.pop_front();
      chk(rdata & e.m, e.d & e.m);
      chk({30'h0, rresp}, {30'h0, e.r});
    end
  end

  initial
  begin
    #300000;
    errors++;
    summarize();
  end

  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    prot = 3'h0;
    write_core_id = 2'h0;
    errors = 0;
    n_tests = 0;
    s = $urandom(32'h7117cb08);
    s = $urandom;
    d = 32'h2 + {31'h0, s[0]};
    dv = 20'(d * 1000);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pcs_pkg::STATUS_OFS, st(2'h0, 20'h003e8, 2'h0, 3'h0), SM);
    chk({30'h0, src_sel}, {30'h0, pcs_pkg::IRC_SOURCE});
    rd(pcs_pkg::SDUR_OFS, 32'h10, 32'hffff);
    rd(8'hfc, 32'h0, 32'hffffffff, pcs_pkg::RESP_SLVERR);
    wr(8'hfc, s, pcs_pkg::RESP_SLVERR);
    // only the io core may move the divider
    wr(pcs_pkg::SYS_DIV_OFS, {24'h0, s[15:8] | 8'h1}, 2'h0, 2'h1);
    rd(pcs_pkg::SYS_DIV_OFS, 32'h1, 32'hff);
    wr(pcs_pkg::SYS_DIV_OFS, d, 2'h0, pcs_pkg::IO_CORE_ID);
    wr(pcs_pkg::SYS_DIV_OFS, 32'h0, 2'h0, pcs_pkg::IO_CORE_ID);
    rd(pcs_pkg::SYS_DIV_OFS, d, 32'hff);
    // equal power: direct switch to source 1
    wr(pcs_pkg::MODE_CFG_OFS + 8'h4, 32'h10);
    wr(pcs_pkg::MODE_CTL_OFS, 32'h1);
    n = 0;
    repeat (20)
    begin
      @(posedge aclk);
      n += ramp;
    end
    chk(n, 0);
    rd(pcs_pkg::STATUS_OFS, st(2'h1, dv, 2'h1, 3'h0), SM);
    chk({30'h0, src_sel}, 32'h1);
    @(posedge clk_out);
    t0 = $time;
    @(negedge clk_out);
    chk(32'(($time - t0) / 5), d);
    @(posedge clk_out);
    chk(32'(($time - t0) / 5), 2 * d);
    // higher power level for mode 2: stepped ramp
    wr(pcs_pkg::SDUR_OFS, 32'h2);
    wr(pcs_pkg::DIVC_OFS + 8'h4, 32'h000101f4);
    wr(pcs_pkg::DIVE_OFS + 8'h4, 32'hfa0);
    wr(pcs_pkg::DIVC_OFS + 8'h8, 32'h000101f4);
    wr(pcs_pkg::DIVS_OFS + 8'h8, 32'hfa0);
    wr(pcs_pkg::MODE_CFG_OFS + 8'h8, 32'h23);
    t0 = $time;
    wr(pcs_pkg::MODE_CTL_OFS, 32'h2);
    rd(pcs_pkg::MODE_CTL_OFS, 32'h100, 32'h100);
    wr(pcs_pkg::MODE_CTL_OFS, 32'h0);
    wait_idle();
    chk({31'h0, ($time - t0) / 5 >= 48}, 32'h1);
    rd(pcs_pkg::STATUS_OFS, st(2'h2, dv, 2'h2, 3'h3), SM);
    chk({30'h0, src_sel}, 32'h2);
    // same mode again after a power level change
    wr(pcs_pkg::MODE_CFG_OFS + 8'h8, 32'h21);
    wr(pcs_pkg::MODE_CTL_OFS, 32'h2);
    rd(pcs_pkg::MODE_CTL_OFS, 32'h102, 32'h103);
    wait_idle();
    rd(pcs_pkg::STATUS_OFS, st(2'h2, dv, 2'h2, 3'h1), SM);
    summarize();
  end
endmodule : progressive_clock_switching_tb_top
`default_nettype wire
